/* File: inc/tmc_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants and types for the terminal memory card
// ----------------------------------------------------------------------------
package tmc_pkg;

  // Bus widths
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int RAM_AW      = 10;
  localparam int RAM_DEPTH   = 1024;
  localparam int FW_CHIPS    = 16;
  localparam int FW_WORD_AW  = 8;
  localparam int SW_GROUPS   = 4;

  // Address field positions
  localparam int DEC_HI      = 15;   // Top of the memory decode field
  localparam int DEC_LO      = 10;   // Bottom of the memory decode field
  localparam int FW_SEL_LO   = 12;   // Firmware region decode bottom bit
  localparam int CHIP_HI     = 11;
  localparam int CHIP_LO     = 8;
  localparam int IO_SEL_LO   = 13;
  localparam int SW_SEL_HI   = 1;

  // Default decode values, overridable at the top module
  localparam logic [5:0] RAM_REGION_DEF = 6'h01;
  localparam logic [3:0] FW_REGION_DEF  = 4'h0;
  localparam logic [2:0] IO_REGION_DEF  = 3'h7;

  // Reset values
  localparam logic [DATA_W-1:0]   STATUS_RST  = 8'h00;
  localparam logic [DATA_W-1:0]   DATA_RST    = 8'h00;
  localparam logic [FW_CHIPS-1:0] CHIP_EN_RST = 16'h0000;

  // Firmware chip data passes a two-stage synchroniser and one capture stage
  localparam logic [1:0] FW_SETTLE_CYCLES = 2'h3;

  // Processor bus request, sampled as one bundle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              mem_rd;
    logic              mem_wr;
    logic              io_rd;
    logic              io_wr;
    logic              clear;
  } tmc_bus_s;

  localparam tmc_bus_s BUS_IDLE = '0;

  // Read/write control states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RAM_RD = 5'b00010,
    ST_FW_RD  = 5'b00100,
    ST_DRIVE  = 5'b01000,
    ST_DONE   = 5'b10000
  } tmc_state_e;

endpackage
`default_nettype wire

/* File: verilog/tmc_ram.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Character RAM: single port, registered read data
// ----------------------------------------------------------------------------
module tmc_ram #(
  parameter int AW    = 10,
  parameter int DW    = 8,
  parameter int DEPTH = 1024
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  // Old word is read out on a write cycle; read data always from a register
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
`default_nettype wire

/* File: verilog/tmc_card.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Terminal memory card: RAM, firmware chip select, switch reads, status
// ----------------------------------------------------------------------------
// What this block does
// - Watch all sixteen processor address lines continuously.
// - Decode address bits 15..10 into RAM, firmware or nothing.
// - Character RAM holds 1024 bytes addressed by bits 9..0.
// - RAM write stores the data bus byte at the low address.
// - RAM read fetches the addressed byte for the bus drivers.
// - Read/write control runs RAM cycles and returns Ready.
// - Firmware access enables exactly one of sixteen chips from bits 11..8.
// - Firmware gives up to 4096 bytes, bits 7..0 pick the word.
// - Drive memory data onto the bus only for RAM or firmware reads.
// - I/O control detects I/O strobes addressed by bits 15..13.
// - For I/O input, bits 1..0 select one of four switch groups.
// - Switch word is driven only during a switch input operation.
// - I/O output to the card loads the status register from data.
// - Status register outputs drive the mode indicators continuously.
// - Global clear empties status and resets the read/write control.
module tmc_card
  import tmc_pkg::*;
#(
  parameter logic [5:0] RAM_REGION = RAM_REGION_DEF,
  parameter logic [3:0] FW_REGION  = FW_REGION_DEF,
  parameter logic [2:0] IO_REGION  = IO_REGION_DEF
) (
  input  wire logic                            CORE_CLK,
  input  wire logic                            RESET_N,
  input  wire logic [ADDR_W-1:0]               ADDR,
  input  wire logic [DATA_W-1:0]               DATA_IN,
  input  wire logic                            MEM_READ,
  input  wire logic                            MEM_WRITE,
  input  wire logic                            IO_READ_PULSE,
  input  wire logic                            IO_WRITE_PULSE,
  input  wire logic                            GLOBAL_CLEAR,
  input  wire logic [SW_GROUPS*DATA_W-1:0]     SWITCH_WORDS,
  input  wire logic [DATA_W-1:0]               FW_DATA,
  output var  logic [DATA_W-1:0]               DATA_OUT,
  output var  logic                            DATA_OE,
  output var  logic                            READY,
  output var  logic [DATA_W-1:0]               STATUS_IND,
  output var  logic [FW_CHIPS-1:0]             FW_CHIP_EN,
  output var  logic [FW_WORD_AW-1:0]           FW_WORD_ADDR
);

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic [FW_CHIPS-1:0] chip_onehot(input logic [3:0] idx);
    chip_onehot = FW_CHIPS'(1) << idx;
  endfunction

  function automatic logic [DATA_W-1:0] switch_pick(
    input logic [SW_GROUPS*DATA_W-1:0] words,
    input logic [1:0]                  sel
  );
    switch_pick = words[sel*DATA_W +: DATA_W];
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  tmc_bus_s                          bus_meta_reg;
  tmc_bus_s                          bus_reg;
  logic                              io_wr_prev_reg;
  logic                              io_rd_prev_reg;
  logic [SW_GROUPS*DATA_W-1:0]       sw_meta_reg;
  logic [SW_GROUPS*DATA_W-1:0]       sw_reg;
  logic [DATA_W-1:0]                 fw_meta_reg;
  logic [DATA_W-1:0]                 fw_sync_reg;

  // Every bus pin comes from the processor's own timing, so all pass two stages
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      bus_meta_reg <= BUS_IDLE;
      bus_reg      <= BUS_IDLE;
    end else begin
      bus_meta_reg <= '{addr: ADDR, data: DATA_IN, mem_rd: MEM_READ,
                        mem_wr: MEM_WRITE, io_rd: IO_READ_PULSE,
                        io_wr: IO_WRITE_PULSE, clear: GLOBAL_CLEAR};
      bus_reg      <= bus_meta_reg;
    end
  end

  // Switches and firmware chip data are static or slow; same two stages
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      sw_meta_reg <= '0;
      sw_reg      <= '0;
      fw_meta_reg <= DATA_RST;
      fw_sync_reg <= DATA_RST;
    end else begin
      sw_meta_reg <= SWITCH_WORDS;
      sw_reg      <= sw_meta_reg;
      fw_meta_reg <= FW_DATA;
      fw_sync_reg <= fw_meta_reg;
    end
  end

  // Edge history for the I/O strobes, taken from the second stage only
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      io_wr_prev_reg <= 1'b0;
      io_rd_prev_reg <= 1'b0;
    end else begin
      io_wr_prev_reg <= bus_reg.io_wr;
      io_rd_prev_reg <= bus_reg.io_rd;
    end
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic ram_sel;
  logic fw_sel;
  logic io_sel;
  logic io_wr_rise;
  logic io_rd_rise;
  logic req_live;

  assign ram_sel    = bus_reg.addr[DEC_HI:DEC_LO] == RAM_REGION;
  assign fw_sel     = !ram_sel && bus_reg.addr[DEC_HI:FW_SEL_LO] == FW_REGION;
  assign io_sel     = bus_reg.addr[DEC_HI:IO_SEL_LO] == IO_REGION;
  assign io_wr_rise = bus_reg.io_wr && !io_wr_prev_reg && io_sel;
  assign io_rd_rise = bus_reg.io_rd && !io_rd_prev_reg && io_sel;
  // A cycle ends when the processor lets go of memory read, memory write and I/O input; the I/O output strobe is not watched
  assign req_live   = bus_reg.mem_rd || bus_reg.mem_wr || bus_reg.io_rd;

  // --------------------------------------------------------------------------
  // Character RAM
  // --------------------------------------------------------------------------
  tmc_state_e        state_reg;
  logic              ram_wr_en;
  logic [DATA_W-1:0] ram_rdata;

  // Write happens once, in the idle cycle that accepts the request
  assign ram_wr_en = state_reg == ST_IDLE && bus_reg.mem_wr && ram_sel
                     && !bus_reg.mem_rd && !bus_reg.clear;

  tmc_ram #(
    .AW    (RAM_AW),
    .DW    (DATA_W),
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .clk   (CORE_CLK),
    .wr_en (ram_wr_en),
    .addr  (bus_reg.addr[RAM_AW-1:0]),
    .wdata (bus_reg.data),
    .rdata (ram_rdata)
  );

  // --------------------------------------------------------------------------
  // Read/write control
  // --------------------------------------------------------------------------
  logic [1:0] settle_reg;

  // Global clear returns the control to idle with the bus released
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || bus_reg.clear) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (bus_reg.mem_rd && ram_sel) begin
            state_reg <= ST_RAM_RD;
          end else if (bus_reg.mem_rd && fw_sel) begin
            state_reg <= ST_FW_RD;
          end else if (bus_reg.mem_wr && ram_sel) begin
            state_reg <= ST_DONE;
          end else if (io_rd_rise) begin
            state_reg <= ST_DONE;
          end
        end
        ST_RAM_RD: begin
          state_reg <= ST_DRIVE;
        end
        ST_FW_RD: begin
          if (settle_reg == FW_SETTLE_CYCLES) begin
            state_reg <= ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          if (!req_live) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Chip data crosses a synchroniser, so wait for it to settle
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || bus_reg.clear || state_reg != ST_FW_RD) begin
      settle_reg <= 2'h0;
    end else if (settle_reg != FW_SETTLE_CYCLES) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Firmware chip select
  // --------------------------------------------------------------------------
  // Enables are held for the whole read so the chip output stays stable
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || bus_reg.clear) begin
      FW_CHIP_EN   <= CHIP_EN_RST;
      FW_WORD_ADDR <= '0;
    end else if (state_reg == ST_IDLE && bus_reg.mem_rd && fw_sel && !ram_sel) begin
      FW_CHIP_EN   <= chip_onehot(bus_reg.addr[CHIP_HI:CHIP_LO]);
      FW_WORD_ADDR <= bus_reg.addr[FW_WORD_AW-1:0];
    end else if (state_reg == ST_IDLE) begin
      FW_CHIP_EN   <= CHIP_EN_RST;
    end
  end

  // --------------------------------------------------------------------------
  // Bus drivers and Ready
  // --------------------------------------------------------------------------
  // Drivers and Ready rise together on reads, so data is valid whenever a read shows Ready; a RAM write raises Ready alone
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || bus_reg.clear) begin
      DATA_OUT <= DATA_RST;
      DATA_OE  <= 1'b0;
      READY    <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          DATA_OE <= 1'b0;
          READY   <= 1'b0;
          if (bus_reg.mem_wr && ram_sel && !bus_reg.mem_rd) begin
            READY <= 1'b1;
          end else if (io_rd_rise && !bus_reg.mem_rd) begin
            DATA_OUT <= switch_pick(sw_reg, bus_reg.addr[SW_SEL_HI:0]);
            DATA_OE  <= 1'b1;
            READY    <= 1'b1;
          end
        end
        ST_DRIVE: begin
          DATA_OUT <= fw_sel ? fw_sync_reg : ram_rdata;
          DATA_OE  <= 1'b1;
          READY    <= 1'b1;
        end
        ST_DONE: begin
          if (!req_live) begin
            DATA_OE <= 1'b0;
            READY   <= 1'b0;
          end
        end
        default: begin
          DATA_OE <= 1'b0;
          READY   <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Status indicator register
  // --------------------------------------------------------------------------
  // Loaded on the rising edge of the output strobe, driven out at all times
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || bus_reg.clear) begin
      STATUS_IND <= STATUS_RST;
    end else if (io_wr_rise) begin
      STATUS_IND <= bus_reg.data;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  a_ram_write_ready: assert property (
    ram_wr_en |=> READY && !DATA_OE)
    else $error("RAM write not acknowledged one cycle later");

  a_ram_read_data: assert property (
    state_reg == ST_IDLE && bus_reg.mem_rd && ram_sel && !bus_reg.clear
    ##1 !bus_reg.clear [*2] |=> DATA_OE && READY && DATA_OUT == $past(ram_rdata))
    else $error("RAM read data not driven three cycles after accept");

  a_fw_one_chip: assert property (
    state_reg == ST_FW_RD |-> $onehot(FW_CHIP_EN))
    else $error("Firmware read without exactly one chip enable");

  a_fw_chip_idx: assert property (
    state_reg == ST_IDLE && bus_reg.mem_rd && fw_sel && !bus_reg.clear
    |=> FW_CHIP_EN == chip_onehot($past(bus_reg.addr[CHIP_HI:CHIP_LO]))
        && FW_WORD_ADDR == $past(bus_reg.addr[FW_WORD_AW-1:0]))
    else $error("Firmware chip or word address wrong");

  a_fw_settle: assert property (
    $rose(state_reg == ST_FW_RD) && !bus_reg.clear |-> !READY [*4])
    else $error("Firmware Ready before chip data settled");

  a_drive_only_read: assert property (
    DATA_OE |-> $past(bus_reg.mem_rd) || $past(bus_reg.io_rd))
    else $error("Bus driven without a read in progress");

  a_ready_has_oe: assert property (
    READY && !DATA_OE |-> $past(bus_reg.mem_wr))
    else $error("Ready without read data or write");

  a_switch_word: assert property (
    io_rd_rise && state_reg == ST_IDLE && !bus_reg.mem_rd && !bus_reg.clear
    |=> DATA_OE && DATA_OUT == $past(switch_pick(sw_reg, bus_reg.addr[SW_SEL_HI:0])))
    else $error("Switch word not driven after I/O input");

  a_status_load: assert property (
    io_wr_rise && !bus_reg.clear |=> STATUS_IND == $past(bus_reg.data))
    else $error("Status register did not load from data bus");

  a_status_hold: assert property (
    !io_wr_rise && !bus_reg.clear |=> $stable(STATUS_IND))
    else $error("Status register changed without an output strobe");

  a_clear_all: assert property (
    bus_reg.clear |=> STATUS_IND == STATUS_RST && state_reg == ST_IDLE
                      && !READY && !DATA_OE)
    else $error("Global clear did not reset status and control");

  a_release_bus: assert property (
    state_reg == ST_DONE && !req_live && !bus_reg.clear |=> !DATA_OE ##1 !DATA_OE)
    else $error("Bus not released after strobes dropped");

endmodule
`default_nettype wire

/* File: verification/tmc_fw_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Firmware chip stack seen from the card's pins
// ----
module tmc_fw_model
  import tmc_pkg::*;
#(
  parameter int ACCESS_NS = 40
) (
  input  wire logic                  clk,
  input  wire logic [FW_CHIPS-1:0]   chip_en,
  input  wire logic [FW_WORD_AW-1:0] word_addr,
  output wire logic [DATA_W-1:0]     fw_data,
  output var  logic                  multi_sel
);
  logic [DATA_W-1:0] last_reg;
  logic [DATA_W-1:0] word_val;
  logic [DATA_W-1:0] fw_now;
  logic [3:0]        chip_idx;

  // Index of the enabled chip
  always_comb begin
    chip_idx = 4'h0;
    for (int i = 0; i < FW_CHIPS; i++) begin
      if (chip_en[i]) chip_idx = i[3:0];
    end
  end

  // Contents easy to predict per chip and word
  always_comb word_val = {chip_idx, 4'h9} ^ word_addr;

  // Not exactly one chip selected: inverted last value, so a stale byte never passes
  always_comb fw_now = ($countones(chip_en) == 1) ? word_val : ~last_reg;
  assign #ACCESS_NS fw_data = fw_now;  // Slow chip access time

  initial last_reg = 8'h5a;
  initial multi_sel = 1'b0;
  always @(posedge clk) last_reg <= fw_data;
  // Sticky flag if more than one chip is ever enabled
  always @(posedge clk) multi_sel <= multi_sel | ($countones(chip_en) > 1);
endmodule
`default_nettype wire

/* File: verification/terminal_memory_card_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module terminal_memory_card_test
  import tmc_pkg::*;
;
  // ----
  // Bench signals and instances
  // ----
  logic        core_clk, reset_n, mem_read, mem_write, io_rd, io_wr, gclear;
  logic [15:0] addr, fw_chip_en, snap_en;
  logic [7:0]  cpu_data, last_bus, data_out, status_ind, fw_word_addr, fw_data, snap_wa;
  logic [31:0] switch_words;
  logic        cpu_drv, data_oe, ready, multi_sel, snap_oe;
  wire  [7:0]  data_bus;
  int          fails, total_checks;
  localparam logic [15:0] RAM_BASE = 16'h2000;

  // Resolved data bus; nobody driving shows the inverted last level
  assign data_bus = data_oe ? data_out : (cpu_drv ? cpu_data : ~last_bus);
  always @(posedge core_clk) last_bus <= data_bus;
  always @(posedge core_clk) if (data_oe === 1'b1 && cpu_drv) `CHK(data_oe, 1'b0)

  tmc_card #(.RAM_REGION(6'h08), .FW_REGION(4'h0), .IO_REGION(3'h7)) i_tmc_card (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .ADDR(addr), .DATA_IN(data_bus),
    .MEM_READ(mem_read), .MEM_WRITE(mem_write), .IO_READ_PULSE(io_rd),
    .IO_WRITE_PULSE(io_wr), .GLOBAL_CLEAR(gclear), .SWITCH_WORDS(switch_words),
    .FW_DATA(fw_data), .DATA_OUT(data_out), .DATA_OE(data_oe), .READY(ready),
    .STATUS_IND(status_ind), .FW_CHIP_EN(fw_chip_en), .FW_WORD_ADDR(fw_word_addr));

  tmc_fw_model #(.ACCESS_NS(40)) i_tmc_fw_model (
    .clk(core_clk), .chip_en(fw_chip_en), .word_addr(fw_word_addr),
    .fw_data(fw_data), .multi_sel(multi_sel));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----
  // Bus tasks
  // ----
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  // kind 0 memory read, 1 memory write, 2 I/O input; strobe held until Ready
  task automatic bus_op(input logic [15:0] a, input int kind, input logic [7:0] wd,
                        output logic [7:0] rd, output logic got);
    int n;
    addr = a;
    cpu_data = wd;
    cpu_drv = (kind == 1);
    mem_read = (kind == 0);
    mem_write = (kind == 1);
    io_rd = (kind == 2);
    got = 1'b0;
    rd = 8'h00;
    n = 0;
    while (!got && n < 30) begin
      @(posedge core_clk);
      #1;
      n++;
      if (ready === 1'b1) begin
        got = 1'b1;
        rd = data_bus;
        snap_oe = data_oe;
        snap_en = fw_chip_en;
        snap_wa = fw_word_addr;
      end
    end
    #4;
    {mem_read, mem_write, io_rd, cpu_drv} = 4'h0;
    n = 0;
    while (ready !== 1'b0 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(ready, 1'b0)
    #4;
  endtask

  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    cpu_data = d;
    cpu_drv = 1'b1;
    io_wr = 1'b1;
    step(6);
    io_wr = 1'b0;
    cpu_drv = 1'b0;
    step(4);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    `CHK({data_oe, ready, data_out, status_ind}, 18'h0)
    `CHK({fw_chip_en, fw_word_addr}, 24'h0)
  endtask

  // Boundary words, one at the last cell of a 12 x 80 screen
  task automatic t_ram();
    logic [9:0] idx [3] = '{10'h000, 10'h3bf, 10'h3ff};
    logic [7:0] val [3] = '{8'h41, 8'h5a, 8'hc5};
    logic [7:0] rd;
    logic       got;
    for (int i = 0; i < 3; i++) begin
      bus_op(RAM_BASE | 16'(idx[i]), 1, val[i], rd, got);
      `CHK(got, 1'b1)
      `CHK(snap_oe, 1'b0)
    end
    for (int i = 0; i < 3; i++) begin
      bus_op(RAM_BASE | 16'(idx[i]), 0, 8'h00, rd, got);
      `CHK({got, snap_oe}, 2'b11)
      `CHK(rd, val[i])
    end
  endtask

  task automatic t_fw();
    logic [7:0] rd, w;
    logic       got;
    for (int c = 0; c < 16; c++) begin
      w = 8'(c * 17);
      bus_op({4'h0, c[3:0], w}, 0, 8'h00, rd, got);
      `CHK({got, snap_oe}, 2'b11)
      `CHK(snap_en, 16'h0001 << c)
      `CHK(snap_wa, w)
      `CHK(rd, {c[3:0], 4'h9} ^ w)
    end
    `CHK(multi_sel, 1'b0)
  endtask

  task automatic t_io_in();
    logic [7:0] rd;
    logic       got;
    switch_words = 32'h9a7ec315;
    for (int g = 0; g < 4; g++) begin
      bus_op(16'hfffc | 16'(g), 2, 8'h00, rd, got);
      `CHK({got, snap_oe}, 2'b11)
      `CHK(rd, switch_words[8*g +: 8])
    end
    `CHK(data_oe, 1'b0)
  endtask

  task automatic t_io_out();
    io_write(16'he000, 8'ha5);
    `CHK(status_ind, 8'ha5)
    step(5);
    `CHK(status_ind, 8'ha5)
    io_write(16'h8000, 8'h3c);
    `CHK(status_ind, 8'ha5)
  endtask

  task automatic t_unmapped();
    logic [15:0] a [2] = '{16'h8000, 16'h2400};
    logic [7:0]  rd;
    logic        got;
    for (int i = 0; i < 2; i++) begin
      bus_op(a[i], 0, 8'h00, rd, got);
      `CHK(got, 1'b0)
      `CHK(data_oe, 1'b0)
    end
  endtask

  // Clear in the middle of a RAM read; stored words survive
  task automatic t_clear();
    logic [7:0] rd;
    logic       got;
    io_write(16'he000, 8'h77);
    `CHK(status_ind, 8'h77)
    addr = RAM_BASE;
    mem_read = 1'b1;
    step(2);
    gclear = 1'b1;
    step(4);
    `CHK({status_ind, ready, data_oe}, 10'h0)
    mem_read = 1'b0;
    gclear = 1'b0;
    step(6);
    bus_op(RAM_BASE, 0, 8'h00, rd, got);
    `CHK(rd, 8'h41)
  endtask

  task automatic summarize();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  end

  initial begin
    {reset_n, mem_read, mem_write, io_rd, io_wr, gclear, cpu_drv} = 7'h0;
    addr = 16'h0000;
    cpu_data = 8'h00;
    switch_words = 32'h0;
    last_bus = 8'h00;
    step(6);
    reset_n = 1'b1;
    step(1);
    t_reset();
    t_ram();
    t_fw();
    t_io_in();
    t_io_out();
    t_unmapped();
    t_clear();
    summarize();
  end
endmodule
`default_nettype wire
